//--- rtl/scg_guard_timing.sv
// Overview of operation
// - Force bit makes every received character parity-bad
// - Extra guard is nine bits across two registers
// - Keep extra guard between consecutive transmit starts
// - First transmit waits block guard after receive start
// - Extra guard resets 12; T0 floor 12, T1 11
// - Block guard resets 0x10, extra guard 0x0c
// - Receiver checks even parity when enabled
// - T0 break detection extends next transmit start
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scg_guard_timing
  import scg_pkg::*;
#(
  parameter int ETU_CYCLES = ETU_CYCLES_DFLT,
  parameter int TX_DEPTH   = 2
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output scg_rx_char_type        rx_char,
  output logic                   rx_valid,
  input  wire logic              io_in,
  output logic                   io_out,
  output logic                   io_oe
);
  localparam int DIV_W = $clog2(ETU_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ETU_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_MID  = DIV_W'(ETU_CYCLES / 2);

  // ==========================================================================
  // Register bus
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [7:0]        w_byte;
  logic              w_lane;
  logic              w_held;
  logic [7:0]        parity_control;
  logic [7:0]        block_guard_time;
  logic [7:0]        extra_guard_time;
  logic [7:0]        mode;
  logic              break_seen;
  logic              last_rx_pe;
  scg_state_type     state;

  wire        do_write = aw_held & w_held & ~s_axil_bvalid;
  wire [15:0] wr_idx   = aw_addr[17:2];
  wire [15:0] rd_idx   = s_axil_araddr[17:2];
  wire        wr_en    = do_write & w_lane;
  wire        wr_pc    = wr_en & (wr_idx == IDX_PARITY_CONTROL);
  wire        wr_bg    = wr_en & (wr_idx == IDX_BLOCK_GUARD);
  wire        wr_eg    = wr_en & (wr_idx == IDX_EXTRA_GUARD);
  wire        wr_mode  = wr_en & (wr_idx == IDX_MODE);
  wire        wr_stat  = wr_en & (wr_idx == IDX_STATUS);
  wire        wr_hit   = (wr_idx == IDX_PARITY_CONTROL) | (wr_idx == IDX_BLOCK_GUARD)
                       | (wr_idx == IDX_EXTRA_GUARD) | (wr_idx == IDX_MODE)
                       | (wr_idx == IDX_STATUS);
  wire        ar_take  = s_axil_arvalid & s_axil_arready;
  wire [7:0]  status_byte = {4'h0, state == ST_RX, state == ST_TX, last_rx_pe, break_seen};
  wire        rd_pc    = rd_idx == IDX_PARITY_CONTROL;
  wire        rd_bg    = rd_idx == IDX_BLOCK_GUARD;
  wire        rd_eg    = rd_idx == IDX_EXTRA_GUARD;
  wire        rd_mode  = rd_idx == IDX_MODE;
  wire        rd_stat  = rd_idx == IDX_STATUS;
  wire        rd_hit   = rd_pc | rd_bg | rd_eg | rd_mode | rd_stat;
  wire [7:0]  rd_byte  = ({8{rd_pc}} & parity_control) | ({8{rd_bg}} & block_guard_time)
                       | ({8{rd_eg}} & extra_guard_time) | ({8{rd_mode}} & mode)
                       | ({8{rd_stat}} & status_byte);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held        <= 1'b0;
      aw_addr        <= '0;
      s_axil_awready <= 1'b0;
    end else if (s_axil_awvalid & s_axil_awready) begin
      aw_held        <= 1'b1;
      aw_addr        <= s_axil_awaddr;
      s_axil_awready <= 1'b0;
    end else begin
      if (do_write) aw_held <= 1'b0;
      s_axil_awready <= ~aw_held & ~s_axil_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held        <= 1'b0;
      w_byte        <= '0;
      w_lane        <= 1'b0;
      s_axil_wready <= 1'b0;
    end else if (s_axil_wvalid & s_axil_wready) begin
      w_held        <= 1'b1;
      w_byte        <= s_axil_wdata[7:0];
      w_lane        <= s_axil_wstrb[0];
      s_axil_wready <= 1'b0;
    end else begin
      if (do_write) w_held <= 1'b0;
      s_axil_wready <= ~w_held & ~s_axil_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= '0;
      s_axil_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b1;
      s_axil_rdata   <= {24'h000000, rd_byte};
      s_axil_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else begin
      if (s_axil_rready) s_axil_rvalid <= 1'b0;
      s_axil_arready <= ~s_axil_rvalid;
    end
  end

  // Reserved bits are masked at write time so they always read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_control   <= RST_PARITY_CONTROL;
      block_guard_time <= RST_BLOCK_GUARD;
      extra_guard_time <= RST_EXTRA_GUARD;
      mode             <= RST_MODE;
    end else begin
      if (wr_pc)   parity_control   <= w_byte & MASK_PARITY_CONTROL;
      if (wr_bg)   block_guard_time <= w_byte & MASK_BLOCK_GUARD;
      if (wr_eg)   extra_guard_time <= w_byte;
      if (wr_mode) mode             <= w_byte & MASK_MODE;
    end
  end

  // ==========================================================================
  // Line sampling and unit divider
  logic             io_sync1;
  logic             io_sync2;
  logic             io_prev;
  logic [DIV_W-1:0] etu_div;
  logic             tx_start;

  wire line     = io_sync2;
  wire rx_start = (state == ST_IDLE) & io_prev & ~line;
  wire etu_tick = etu_div == DIV_LAST;
  wire etu_mid  = etu_div == DIV_MID;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_sync1 <= 1'b1;
      io_sync2 <= 1'b1;
      io_prev  <= 1'b1;
    end else begin
      io_sync1 <= io_in;
      io_sync2 <= io_sync1;
      io_prev  <= io_sync2;
    end
  end

  // Divider realigns on every start bit so unit edges track the character
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_start || tx_start || etu_tick) begin
      etu_div <= '0;
    end else begin
      etu_div <= etu_div + 1'b1;
    end
  end

  // ==========================================================================
  // Guard timers
  logic [9:0] egt_cnt;
  logic [9:0] bgt_cnt;
  logic       rx_since_tx;
  logic       break_pending;

  wire        t1        = mode[MODE_T1];
  wire [8:0]  egt_value = {block_guard_time[BG_EGT_MSB], extra_guard_time};
  wire [8:0]  egt_floor = t1 ? EGT_MIN_T1 : EGT_MIN_T0;
  wire [8:0]  egt_eff   = (egt_value < egt_floor) ? egt_floor : egt_value;
  wire [9:0]  egt_need  = {1'b0, egt_eff} + (break_pending ? BREAK_EXTRA_ETU : 10'h000);
  wire [9:0]  bgt_need  = {5'h00, block_guard_time[BG_FIELD_MSB:0]};
  wire        guard_ok  = rx_since_tx ? (bgt_cnt >= bgt_need)
                                      : (egt_cnt >= egt_need);
  wire        fifo_valid;
  wire [7:0]  fifo_data;

  assign tx_start = (state == ST_IDLE) & ~rx_start & fifo_valid & guard_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      egt_cnt <= '1;
      bgt_cnt <= '1;
    end else begin
      if (tx_start)                     egt_cnt <= '0;
      else if (etu_tick && ~&egt_cnt)   egt_cnt <= egt_cnt + 1'b1;
      if (rx_start)                     bgt_cnt <= '0;
      else if (etu_tick && ~&bgt_cnt)   bgt_cnt <= bgt_cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_since_tx <= 1'b0;
    end else if (rx_start) begin
      rx_since_tx <= 1'b1;
    end else if (tx_start) begin
      rx_since_tx <= 1'b0;
    end
  end

  scg_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (tx_start)
  );

  // ==========================================================================
  // Character engine
  logic [3:0] bit_idx;
  logic [9:0] tx_frame;
  logic [7:0] rx_shift;

  wire brk_sample = (state == ST_TX) & etu_mid & (bit_idx == TX_LAST_BIT);
  wire brk_hit    = brk_sample & ~t1 & ~parity_control[PC_BREAK_DET_DIS] & ~line;
  wire rx_bit     = (state == ST_RX) & etu_mid;
  wire rx_false   = rx_bit & (bit_idx == 4'h0) & line;
  wire rx_done    = rx_bit & (bit_idx == RX_PARITY_BIT);
  wire rx_odd     = ^{rx_shift, line};
  wire rx_pe      = (~parity_control[PC_PARITY_DIS] & rx_odd)
                  | parity_control[PC_FORCE_RX_PE];
  wire clr_break  = wr_stat & w_byte[SB_BREAK];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rx_start)      state <= ST_RX;
          else if (tx_start) state <= ST_TX;
        end
        ST_RX: begin
          if (rx_false || rx_done) state <= ST_IDLE;
        end
        ST_TX: begin
          if (etu_tick && bit_idx == TX_LAST_BIT) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_start || tx_start) begin
      bit_idx <= '0;
    end else if (etu_tick && state != ST_IDLE) begin
      bit_idx <= bit_idx + 1'b1;
    end
  end

  // Open-drain line: only zeros are driven, ones are released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_frame <= '1;
      io_oe    <= 1'b0;
      io_out   <= 1'b0;
    end else if (tx_start) begin
      tx_frame <= {^fifo_data, fifo_data, 1'b0};
      io_oe    <= 1'b1;
    end else if (state == ST_TX && etu_tick) begin
      tx_frame <= {1'b1, tx_frame[9:1]};
      io_oe    <= ~tx_frame[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_shift <= '0;
      rx_valid <= 1'b0;
      rx_char  <= '0;
    end else begin
      rx_valid <= rx_done;
      if (rx_bit && bit_idx != 4'h0 && bit_idx != RX_PARITY_BIT) begin
        rx_shift <= {line, rx_shift[7:1]};
      end
      if (rx_done) begin
        rx_char <= '{data: rx_shift, parity_error: rx_pe};
      end
    end
  end

  // Set wins over a simultaneous software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_seen    <= 1'b0;
      break_pending <= 1'b0;
      last_rx_pe    <= 1'b0;
    end else begin
      break_seen <= brk_hit | (break_seen & ~clr_break);
      if (brk_sample) break_pending <= brk_hit;
      if (rx_done)    last_rx_pe    <= rx_pe;
    end
  end

endmodule : scg_guard_timing
`default_nettype wire

//--- rtl/scg_pkg.sv
package scg_pkg;

  // ==========================================================================
  // Register map (printed offsets are indices; byte address = 4 * index)
  localparam int          ADDR_W             = 18;
  localparam logic [15:0] IDX_PARITY_CONTROL = 16'hfe11;
  localparam logic [15:0] IDX_BLOCK_GUARD    = 16'hfe16;
  localparam logic [15:0] IDX_EXTRA_GUARD    = 16'hfe17;
  localparam logic [15:0] IDX_MODE           = 16'hfe18;
  localparam logic [15:0] IDX_STATUS         = 16'hfe19;

  // ==========================================================================
  // Reset values and write masks
  localparam logic [7:0] RST_PARITY_CONTROL = 8'h00;
  localparam logic [7:0] RST_BLOCK_GUARD    = 8'h10;
  localparam logic [7:0] RST_EXTRA_GUARD    = 8'h0c;
  localparam logic [7:0] RST_MODE           = 8'h00;
  localparam logic [7:0] MASK_PARITY_CONTROL = 8'h7f;
  localparam logic [7:0] MASK_BLOCK_GUARD    = 8'h9f;
  localparam logic [7:0] MASK_MODE           = 8'h01;

  // ==========================================================================
  // Field positions
  localparam int PC_FORCE_RX_PE   = 0;
  localparam int PC_BREAK_DET_DIS = 4;
  localparam int PC_PARITY_DIS    = 6;
  localparam int BG_EGT_MSB       = 7;
  localparam int BG_FIELD_MSB     = 4;
  localparam int MODE_T1          = 0;
  localparam int SB_BREAK         = 0;
  localparam int SB_RX_PE         = 1;
  localparam int SB_TX_BUSY       = 2;
  localparam int SB_RX_BUSY       = 3;

  // ==========================================================================
  // Timing in elementary time units
  localparam logic [8:0] EGT_MIN_T0       = 9'h00c;
  localparam logic [8:0] EGT_MIN_T1       = 9'h00b;
  localparam logic [9:0] BREAK_EXTRA_ETU  = 10'h002;
  localparam logic [3:0] RX_PARITY_BIT    = 4'h9;
  localparam logic [3:0] TX_LAST_BIT      = 4'ha;
  localparam int         ETU_CYCLES_DFLT  = 372;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_error;
  } scg_rx_char_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX   = 2'b01,
    ST_TX   = 2'b11
  } scg_state_type;

endpackage : scg_pkg

//--- rtl/scg_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module scg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  wire [CW-1:0]     next_count = count + CW'(push) - CW'(pop);
  wire [PW-1:0]     wr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0]     rd_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign out_data = mem[rd_ptr];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_inc;
      if (pop)  rd_ptr <= rd_inc;
      count     <= next_count;
      in_ready  <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule : scg_fifo
`default_nettype wire

//--- dv/scg_guard_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scg_guard_timing_properties
  import scg_pkg::*;
#(
  parameter int ETU_CYCLES = ETU_CYCLES_DFLT
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axil_bvalid,
  input wire logic            s_axil_bready,
  input wire logic [1:0]      s_axil_bresp,
  input wire logic            s_axil_arready,
  input wire logic            s_axil_rvalid,
  input wire logic            s_axil_rready,
  input wire logic [31:0]     s_axil_rdata,
  input wire scg_rx_char_type rx_char,
  input wire logic            rx_valid,
  input wire logic            io_oe
);
  localparam int E = ETU_CYCLES;
  logic [31:0] cnt;
  logic        oe_q;
  logic        st;
  // ==========
  // Frame tracker
  // Saturated at reset, so a fresh device looks like a long idle line
  assign st = io_oe && !oe_q && cnt >= 11 * E;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q <= 1'b0;
      cnt  <= 32'(16 * E);
    end else begin
      oe_q <= io_oe;
      cnt  <= st ? 32'd1 : (cnt < 16 * E ? cnt + 32'd1 : cnt);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Properties
  property p_released; cnt >= 10 * E && !st |-> !io_oe; endproperty
  property p_oe_edges; $fell(io_oe) |-> (cnt % E) == 0; endproperty
  property p_start_bit; cnt < E |-> io_oe; endproperty
  property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
  property p_bresp_hold; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp);
  endproperty
  property p_rdata_hold; s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
  endproperty
  property p_rdata_upper; s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000; endproperty
  property p_ar_blocked; s_axil_rvalid |-> !s_axil_arready; endproperty
  a_released: assert property (p_released) else $error("transmit start too close");
  a_oe_edges: assert property (p_oe_edges) else $error("bit edge off unit grid");
  a_start_bit: assert property (p_start_bit) else $error("start bit too short");
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe too long");
  a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped");
  a_rdata_upper: assert property (p_rdata_upper) else $error("read upper bits set");
  a_ar_blocked: assert property (p_ar_blocked) else $error("read accepted early");
  c_start: cover property (st);
  c_rx_bad: cover property (rx_valid && rx_char.parity_error);
  c_decerr: cover property (s_axil_bvalid && s_axil_bresp == RESP_DECERR);
endmodule : scg_guard_timing_properties

bind scg_guard_timing scg_guard_timing_properties #(.ETU_CYCLES(ETU_CYCLES)) i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axil_bvalid(s_axil_bvalid),
  .s_axil_bready(s_axil_bready), .s_axil_bresp(s_axil_bresp),
  .s_axil_arready(s_axil_arready), .s_axil_rvalid(s_axil_rvalid),
  .s_axil_rready(s_axil_rready), .s_axil_rdata(s_axil_rdata),
  .rx_char(rx_char), .rx_valid(rx_valid), .io_oe(io_oe));
`default_nettype wire

//--- dv/scg_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module scg_card_model #(
  parameter int ETU_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic io_oe,
  output logic     io_line
);
  logic drv = 1'b1;
  // Pull-up wins whenever neither side pulls low
  assign io_line = io_oe ? 1'b0 : drv;
  task automatic send(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {^b ^ bad, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      drv <= f[i];
      repeat (ETU_CYCLES - 1) @(posedge aclk);
    end
    @(posedge aclk);
    drv <= 1'b1;
    repeat (2 * ETU_CYCLES) @(posedge aclk);
  endtask : send
  // Pulls low over units 10 and 11 of the next device character
  task automatic brk();
    @(posedge io_oe);
    repeat (10 * ETU_CYCLES) @(posedge aclk);
    drv <= 1'b0;
    repeat (2 * ETU_CYCLES) @(posedge aclk);
    drv <= 1'b1;
  endtask : brk
endmodule : scg_card_model
`default_nettype wire

//--- dv/scg_guard_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scg_guard_timing_tb;
  import scg_pkg::*;
  localparam int E = 8;
  logic aclk, aresetn, tx_valid, tx_ready, rx_valid, io_in, io_out, io_oe, oe_q, ln_q;
  logic [ADDR_W-1:0] s_axil_awaddr, s_axil_araddr;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [7:0] tx_data;
  scg_rx_char_type rx_char;
  int error_cnt, tests_run, cyc, rx_t, st_q[$];
  scg_guard_timing #(.ETU_CYCLES(E)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char), .rx_valid(rx_valid),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  scg_card_model #(.ETU_CYCLES(E)) i_card (.aclk(aclk), .io_oe(io_oe), .io_line(io_in));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==========
  // Start-bit and receive-start monitor
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    oe_q <= io_oe;
    ln_q <= io_in;
    if (io_oe && !oe_q && (st_q.size() == 0 || cyc - st_q[$] > 10 * E)) st_q.push_back(cyc);
    if (!io_in && ln_q && !io_oe && cyc - rx_t > 11 * E) rx_t <= cyc;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic tmo(input string nm);
    chk(nm, 32'h1, 32'h0);
    print_verdict();
  endtask : tmo
  // ==========
  // Register bus master
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_axil_awaddr <= {idx, 2'b00};
    s_axil_wdata <= {24'h000000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axil_awvalid && s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wvalid && s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid === 1'b1 && s_axil_bready) break;
      if (s_axil_bvalid === 1'b1) s_axil_bready <= 1'b1;
    end
    if (n == 100) tmo("bvalid");
    s_axil_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axil_bresp});
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [7:0] ex, input logic [1:0] er,
                    input logic [31:0] msk = 32'hffffffff);
    int n;
    s_axil_araddr <= {idx, 2'b00};
    s_axil_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axil_arvalid && s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid === 1'b1 && s_axil_rready) break;
      if (s_axil_rvalid === 1'b1) s_axil_rready <= 1'b1;
    end
    if (n == 100) tmo("rvalid");
    s_axil_rready <= 1'b0;
    chk("rdata", {24'h000000, ex}, s_axil_rdata & msk);
    chk("rresp", {30'h0, er}, {30'h0, s_axil_rresp});
  endtask : rd
  task automatic send_tx(input int num, output logic stall);
    int k, n;
    stall = 1'b0;
    k = 0;
    st_q.delete();
    tx_data <= 8'h31;
    tx_valid <= 1'b1;
    for (n = 0; n < 30000 && k < num; n++) begin
      @(posedge aclk);
      if (tx_ready === 1'b1) begin
        k++;
        tx_data <= tx_data + 8'h01;
      end else stall = 1'b1;
    end
    tx_valid <= 1'b0;
    for (n = 0; n < 30000 && st_q.size() < num; n++) @(posedge aclk);
    if (k < num || st_q.size() < num) tmo("tx_start");
    repeat (12 * E) @(posedge aclk);
  endtask : send_tx
  // ==========
  // Scenarios
  task automatic t_regs();
    rd(IDX_BLOCK_GUARD, 8'h10, RESP_OKAY);
    rd(IDX_EXTRA_GUARD, 8'h0c, RESP_OKAY);
    rd(16'h0000, 8'h00, RESP_DECERR);
    wr(16'h0000, 8'h55, RESP_DECERR);
    wr(IDX_BLOCK_GUARD, 8'hff, RESP_OKAY);
    rd(IDX_BLOCK_GUARD, 8'h9f, RESP_OKAY);
    wr(IDX_EXTRA_GUARD, 8'ha5, RESP_OKAY);
    rd(IDX_EXTRA_GUARD, 8'ha5, RESP_OKAY);
  endtask : t_regs
  task automatic t_gap(input logic [7:0] md, input logic [7:0] bg, input logic [7:0] eg);
    logic       stall;
    logic [8:0] extra_guard_low_byte, fl, etu;
    int         g;
    extra_guard_low_byte = {bg[BG_EGT_MSB], eg};
    fl = md[MODE_T1] ? EGT_MIN_T1 : EGT_MIN_T0;
    etu = extra_guard_low_byte > fl ? extra_guard_low_byte : fl;
    wr(IDX_MODE, md, RESP_OKAY);
    wr(IDX_BLOCK_GUARD, bg, RESP_OKAY);
    wr(IDX_EXTRA_GUARD, eg, RESP_OKAY);
    send_tx(4, stall);
    chk("tx_full", 32'h1, {31'h0, stall});
    for (int i = 1; i < 4; i++) begin
      g = st_q[i] - st_q[i-1];
      chk("gap", etu * E, (g >= etu * E && g <= etu * E + 2) ? etu * E : g);
    end
  endtask : t_gap
  task automatic t_rx(input logic [7:0] pc, input logic [7:0] b, input logic bad,
                      input logic pe);
    int n;
    wr(IDX_PARITY_CONTROL, pc, RESP_OKAY);
    fork
      i_card.send(b, bad);
      begin
        for (n = 0; n < 20 * E; n++) begin
          @(posedge aclk);
          if (rx_valid === 1'b1) break;
        end
        if (n == 20 * E) tmo("rx_valid");
        chk("rx_data", {24'h000000, b}, {24'h000000, rx_char.data});
        chk("rx_pe", {31'h0, pe}, {31'h0, rx_char.parity_error});
      end
    join
  endtask : t_rx
  task automatic t_bgt();
    logic stall;
    int   d;
    wr(IDX_PARITY_CONTROL, 8'h00, RESP_OKAY);
    wr(IDX_BLOCK_GUARD, 8'h0e, RESP_OKAY);
    i_card.send(8'h77, 1'b0);
    send_tx(1, stall);
    d = st_q[0] - rx_t;
    chk("bgt", 14 * E, (d >= 14 * E && d <= 14 * E + 6) ? 14 * E : d);
  endtask : t_bgt
  task automatic t_brk();
    logic stall;
    int   g;
    wr(IDX_MODE, 8'h00, RESP_OKAY);
    wr(IDX_EXTRA_GUARD, 8'h05, RESP_OKAY);
    fork
      i_card.brk();
      send_tx(2, stall);
    join
    g = st_q[1] - st_q[0];
    chk("brk_gap", 14 * E, (g >= 14 * E && g <= 14 * E + 2) ? 14 * E : g);
    rd(IDX_STATUS, 8'h01, RESP_OKAY, 32'h1);
    wr(IDX_STATUS, 8'h01, RESP_OKAY);
    rd(IDX_STATUS, 8'h00, RESP_OKAY, 32'h1);
    rd(IDX_STATUS, 8'h00, RESP_OKAY, 32'hc);
    chk("io_out", 32'h0, {31'h0, io_out});
  endtask : t_brk
  initial begin
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, tx_valid} = '0;
    {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    s_axil_wstrb = 4'hf;
    tx_data = 8'h00;
    {error_cnt, tests_run, cyc} = '0;
    rx_t = -1000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_gap(8'h00, 8'h90, 8'h02);
    t_gap(8'h00, 8'h10, 8'h05);
    t_gap(8'h01, 8'h10, 8'h05);
    t_gap(8'h01, 8'h10, 8'h0e);
    t_rx(8'h00, 8'ha5, 1'b0, 1'b0);
    t_rx(8'h00, 8'h3c, 1'b1, 1'b1);
    t_rx(8'h01, 8'h5a, 1'b0, 1'b1);
    rd(IDX_STATUS, 8'h02, RESP_OKAY, 32'h2);
    t_rx(8'h40, 8'h96, 1'b1, 1'b0);
    t_bgt();
    t_brk();
    print_verdict();
  end
endmodule : scg_guard_timing_tb
`default_nettype wire
